// file: pkg/dadc_pkg.sv
package dadc_pkg;
    // ******************************************************
    // Data and timing
    // ******************************************************
    localparam int DW = 10;
    localparam int ACC_W = 15;
    localparam int SAMPLE_DIV = 6;
    localparam logic [2:0] DIV_LAST = 3'h5;
    localparam logic [2:0] PH_I = 3'h2;
    localparam logic [2:0] PH_Q = 3'h5;
    localparam int CAL_SKIP = 1;
    localparam int CAL_SAMPLES = 32;
    localparam int CAL_TICKS = 34;
    localparam logic [5:0] CAL_FIRST = 6'h01;
    localparam logic [5:0] CAL_LAST = 6'h21;
    localparam int AVG_SHIFT = 5;
    localparam logic [9:0] CODE_MSB = 10'h200;
    localparam logic signed [10:0] SAT_HI = 11'sh1FF;
    localparam logic signed [10:0] SAT_LO = -11'sh200;
    localparam int FIFO_DEPTH = 8;
    // ******************************************************
    // Register map
    // ******************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_OFFSET = 8'h08;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int CB_BUS_SEL = 0;
    localparam int CB_FORMAT = 1;
    localparam int CB_GAIN = 2;
    localparam int CB_STANDBY = 3;
    localparam int CB_PDOWN = 4;
    localparam int CB_OC_TRIG = 5;
    localparam int OFS_Q_LSB = 16;
    typedef enum logic [1:0] {DADC_CAL_IDLE, DADC_CAL_RUN} dadc_cal_t;
endpackage

// file: verilog/dadc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Bus select high: I word on I bus, Q word on Q bus.
// - Bus select low: I then Q interleaved on I bus, Q bus low.
// - Rising offset trigger starts a correction sequence per channel.
// - Sequence ends within 34 samples, averaging 32 conversions.
// - Averaged offset is subtracted from later conversions, saturating.
// - Format low gives offset binary, high gives two's complement.
// - Offset binary: +full all ones, zero top bit, -full zeros.
// - Two's complement: +full 1FF, zero 000, -full 200.
// - Conversion runs only while standby and power down are low.
// - Standby alone: low power, outputs hold last conversion.
// - Power down forces sleep and wins over standby.
// - Sleep holds last outputs; data pins always driven.
// - Gain select sets full scale range for both channels.
// - Both channels captured together on each sample strobe.

// ******************************************************
// Sample FIFO
// ******************************************************
module dadc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready_out <= (cnt_d != (AW+1)'(DEPTH));
            out_valid_out <= (cnt_d != '0);
        end
    end
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end
    assign out_data_out = mem_q[rd_q];
endmodule // dadc_fifo

// ******************************************************
// Converter output control
// ******************************************************
module dadc_top
    import dadc_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [9:0] RAW_I_IN,
    input wire logic [9:0] RAW_Q_IN,
    output logic SAMPLE_STROBE_OUT,
    output logic GAIN_OUT,
    output logic STANDBY_OUT,
    output logic SLEEP_OUT,
    output logic FIFO_READY_OUT,
    output logic [9:0] I_DATA_OUT,
    output logic [9:0] Q_DATA_OUT
);
    logic [5:0] ctrl_q;
    logic oc_prev_q;
    logic [2:0] div_q;
    logic cap_q;
    logic [9:0] raw_i_q;
    logic [9:0] raw_q_q;
    dadc_cal_t cal_q;
    logic [5:0] cal_cnt_q;
    logic signed [ACC_W-1:0] acc_i_q;
    logic signed [ACC_W-1:0] acc_q_q;
    logic signed [9:0] ofs_i_q;
    logic signed [9:0] ofs_q_q;
    logic [9:0] q_word_q;
    logic q_due_q;
    logic [19:0] fifo_out;
    logic fifo_valid;

    // ******************************************************
    // Register decode
    // ******************************************************
    wire wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    wire wr_ctrl = wb_req && WB_WE_IN && WB_SEL_IN[0]
        && (WB_ADR_IN == REG_CTRL);
    wire bus_par = ctrl_q[CB_BUS_SEL];
    wire fmt_twos = ctrl_q[CB_FORMAT];
    wire sleep = ctrl_q[CB_PDOWN];
    wire standby_request = ctrl_q[CB_STANDBY] && !sleep;
    wire conv = !ctrl_q[CB_STANDBY] && !ctrl_q[CB_PDOWN];
    wire tick = (div_q == '0);
    wire oc_rise = ctrl_q[CB_OC_TRIG] && !oc_prev_q;
    wire [31:0] rd_status = {28'h0000000, !FIFO_READY_OUT, sleep, standby_request,
        cal_q == DADC_CAL_RUN};
    wire [31:0] rd_ofs = {6'h00, ofs_q_q, 6'h00, ofs_i_q};
    wire [31:0] rd_data = (WB_ADR_IN == REG_CTRL) ? {26'h0, ctrl_q} :
        (WB_ADR_IN == REG_STATUS) ? rd_status :
        (WB_ADR_IN == REG_OFFSET) ? rd_ofs : 32'h00000000;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_q <= CTRL_RESET;
            oc_prev_q <= 1'b0;
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
        end else begin
            oc_prev_q <= ctrl_q[CB_OC_TRIG];
            WB_ACK_OUT <= wb_req;
            if (wr_ctrl) begin
                ctrl_q <= WB_DAT_IN[5:0];
            end
            if (wb_req) begin
                WB_DAT_OUT <= rd_data;
            end
        end
    end

    // ******************************************************
    // Sample rate and capture
    // ******************************************************
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            div_q <= '0;
            cap_q <= 1'b0;
            raw_i_q <= '0;
            raw_q_q <= '0;
            SAMPLE_STROBE_OUT <= 1'b0;
            GAIN_OUT <= 1'b0;
            STANDBY_OUT <= 1'b0;
            SLEEP_OUT <= 1'b0;
        end else begin
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 3'h1;
            GAIN_OUT <= ctrl_q[CB_GAIN];
            STANDBY_OUT <= standby_request;
            SLEEP_OUT <= sleep;
            SAMPLE_STROBE_OUT <= tick && conv;
            cap_q <= tick && conv;
            if (tick && conv) begin
                raw_i_q <= RAW_I_IN;
                raw_q_q <= RAW_Q_IN;
            end
        end
    end

    // ******************************************************
    // Offset correction
    // ******************************************************
    wire signed [9:0] c_i = $signed(raw_i_q ^ CODE_MSB);
    wire signed [9:0] c_q = $signed(raw_q_q ^ CODE_MSB);
    wire cal_acc = cap_q && (cal_q == DADC_CAL_RUN)
        && (cal_cnt_q >= CAL_FIRST) && (cal_cnt_q < CAL_LAST);
    wire cal_end = cap_q && (cal_q == DADC_CAL_RUN)
        && (cal_cnt_q == CAL_LAST);

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cal_q <= DADC_CAL_IDLE;
            cal_cnt_q <= '0;
            acc_i_q <= '0;
            acc_q_q <= '0;
            ofs_i_q <= '0;
            ofs_q_q <= '0;
        end else begin
            unique case (cal_q)
                DADC_CAL_IDLE: begin
                    if (oc_rise) begin
                        cal_q <= DADC_CAL_RUN;
                        cal_cnt_q <= '0;
                        acc_i_q <= '0;
                        acc_q_q <= '0;
                        ofs_i_q <= '0;
                        ofs_q_q <= '0;
                    end
                end
                DADC_CAL_RUN: begin
                    if (cap_q) begin
                        cal_cnt_q <= cal_cnt_q + 6'h01;
                    end
                    if (cal_acc) begin
                        acc_i_q <= acc_i_q + ACC_W'(c_i);
                        acc_q_q <= acc_q_q + ACC_W'(c_q);
                    end
                    if (cal_end) begin
                        ofs_i_q <= acc_i_q[AVG_SHIFT +: DW];
                        ofs_q_q <= acc_q_q[AVG_SHIFT +: DW];
                        cal_q <= DADC_CAL_IDLE;
                    end
                end
            endcase
        end
    end

    wire signed [10:0] d_i = 11'(c_i) - 11'(ofs_i_q);
    wire signed [10:0] d_q = 11'(c_q) - 11'(ofs_q_q);
    wire [9:0] s_i = (d_i > SAT_HI) ? 10'h1FF :
        (d_i < SAT_LO) ? 10'h200 : d_i[9:0];
    wire [9:0] s_q = (d_q > SAT_HI) ? 10'h1FF :
        (d_q < SAT_LO) ? 10'h200 : d_q[9:0];

    // ******************************************************
    // Buffer and output formatting
    // ******************************************************
    // Drain runs on in low power, so no stale word delays wake-up
    wire pop = fifo_valid && (div_q == PH_I);
    wire q_end = q_due_q && (div_q == PH_Q);
    wire [9:0] f_i = fmt_twos ? fifo_out[19:10] : fifo_out[19:10] ^ CODE_MSB;
    wire [9:0] f_q = fmt_twos ? fifo_out[9:0] : fifo_out[9:0] ^ CODE_MSB;

    dadc_fifo #(.WIDTH(20), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .in_valid_in(cap_q),
        .in_ready_out(FIFO_READY_OUT),
        .in_data_in({s_i, s_q}),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop),
        .out_data_out(fifo_out)
    );

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            I_DATA_OUT <= '0;
            Q_DATA_OUT <= '0;
            q_word_q <= '0;
            q_due_q <= 1'b0;
        end else if (pop) begin
            I_DATA_OUT <= f_i;
            Q_DATA_OUT <= bus_par ? f_q : '0;
            q_word_q <= f_q;
            q_due_q <= 1'b1;
        end else if (q_end) begin
            // Q word follows on I bus
            if (!bus_par) begin
                I_DATA_OUT <= q_word_q;
                Q_DATA_OUT <= '0;
            end
            q_due_q <= 1'b0;
        end else if (!bus_par) begin
            Q_DATA_OUT <= '0;
        end
    end

    // ******************************************************
    // Checks
    // ******************************************************
    sequence s_trig;
        (cal_q == DADC_CAL_IDLE) && oc_rise;
    endsequence
    sequence s_busy;
        cal_q == DADC_CAL_RUN;
    endsequence
    mux_q_low_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        !$past(bus_par) |-> Q_DATA_OUT == '0)
        else $error("Q bus not low in multiplexed mode");
    par_q_bus_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        $past(pop) && $past(bus_par) |-> Q_DATA_OUT == $past(f_q))
        else $error("Q word missing in parallel mode");
    cal_start_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s_trig |=> s_busy)
        else $error("Correction did not start");
    cal_length_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s_trig |=> s_busy [*8] ##[1:197] !s_busy)
        else $error("Correction exceeded its length");
    hold_lowpwr_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        !$past(conv) && !$past(fifo_valid) && !$past(q_due_q)
        |-> $stable(I_DATA_OUT) && !cap_q)
        else $error("Output changed in low power");
    pd_wins_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        ctrl_q[CB_PDOWN] |=> SLEEP_OUT && !STANDBY_OUT)
        else $error("Power down did not win");
    fmt_ob_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        $past(pop) && !$past(fmt_twos)
        |-> I_DATA_OUT == ($past(fifo_out[19:10]) ^ CODE_MSB))
        else $error("Offset binary coding wrong");
    mux_order_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        pop && !bus_par && conv ##1 (!ctrl_q[CB_BUS_SEL] && conv) [*3]
        |=> I_DATA_OUT == q_word_q)
        else $error("Q word did not follow I word");
    gain_follow_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        ##1 GAIN_OUT == $past(ctrl_q[CB_GAIN]))
        else $error("Gain output not following");
endmodule // dadc_top

// file: test/dadc_host.sv
`timescale 1ns/1ps
// ******************************************************
// Host side stand-in: drives codes, counts captures
// ******************************************************
module dadc_host (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic strobe_in,
    input wire logic [9:0] set_i_in,
    input wire logic [9:0] set_q_in,
    output logic [9:0] raw_i_out,
    output logic [9:0] raw_q_out,
    output int n_cap_out
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            raw_i_out <= 10'h200;
            raw_q_out <= 10'h200;
            n_cap_out <= 0;
        end else begin
            raw_i_out <= set_i_in;
            raw_q_out <= set_q_in;
            n_cap_out <= n_cap_out + int'(strobe_in);
        end
    end
endmodule // dadc_host

// file: test/test_dual_adc_output_control.sv
`timescale 1ns/1ps
module test_dual_adc_output_control
    import dadc_pkg::*;
;
    logic clk, rst, cyc, stb, wen, gain, standby_request, sleep, fr, strobe;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, r;
    logic ack;
    logic [9:0] si, sq, ri, rq, id, qd;
    int n_mismatch, checks, n_cap;
    always #2 clk = ~clk;
    dadc_top i_dadc_top (.MCLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(wen), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .RAW_I_IN(ri), .RAW_Q_IN(rq), .SAMPLE_STROBE_OUT(strobe),
        .GAIN_OUT(gain), .STANDBY_OUT(standby_request), .SLEEP_OUT(sleep),
        .FIFO_READY_OUT(fr), .I_DATA_OUT(id), .Q_DATA_OUT(qd));
    dadc_host i_dadc_host (.clk_in(clk), .rst_in(rst), .strobe_in(strobe),
        .set_i_in(si), .set_q_in(sq), .raw_i_out(ri), .raw_q_out(rq),
        .n_cap_out(n_cap));
    // ******************************************************
    // Shared tasks
    // ******************************************************
    task conclude;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= we;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        wen <= 1'b0;
        if (n == 20) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task strobe_wait;
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (strobe === 1'b1) break;
        end
        if (n == 40) begin
            n_mismatch++;
            conclude();
        end
    endtask
    // Flush pipeline, then I word, Q bus, second half of I bus
    task grab(output logic [9:0] iw, output logic [9:0] qm,
            output logic [9:0] qb);
        repeat (3) strobe_wait();
        repeat (3) @(posedge clk);
        #1 iw = id;
        qb = qd;
        repeat (3) @(posedge clk);
        #1 qm = id;
    endtask
    task set_raw(input logic [9:0] a, input logic [9:0] b);
        @(posedge clk);
        si <= a;
        sq <= b;
    endtask
    // ******************************************************
    // Scenarios
    // ******************************************************
    task t_regs;
        wb(1'b0, REG_CTRL, 32'h0);
        cmp(r, 32'h0);
        wb(1'b0, 8'h40, 32'h0);
        cmp(r, 32'h0);
    endtask
    task t_mux;
        logic [9:0] a, b, c;
        set_raw(10'h3FF, 10'h000);
        grab(a, b, c);
        cmp(a, 32'h3FF);
        cmp(b, 32'h000);
        cmp(c, 32'h000);
        set_raw(10'h200, 10'h200);
        grab(a, b, c);
        cmp(a, 32'h200);
    endtask
    task t_par;
        logic [9:0] a, b, c;
        wb(1'b1, REG_CTRL, 32'h03);
        set_raw(10'h3FF, 10'h000);
        grab(a, b, c);
        cmp(a, 32'h1FF);
        cmp(c, 32'h200);
        set_raw(10'h200, 10'h000);
        grab(a, b, c);
        cmp(a, 32'h000);
        wb(1'b1, REG_CTRL, 32'h07);
        repeat (2) @(posedge clk);
        cmp(gain, 32'h1);
    endtask
    task t_power;
        int n;
        wb(1'b1, REG_CTRL, 32'h0F);
        repeat (4) @(posedge clk);
        n = n_cap;
        set_raw(10'h3FF, 10'h3FF);
        repeat (40) @(posedge clk);
        cmp(n_cap - n, 32'h0);
        cmp(standby_request, 32'h1);
        cmp({qd, id}, 32'h80000);
        wb(1'b1, REG_CTRL, 32'h1F);
        repeat (40) @(posedge clk);
        cmp(sleep, 32'h1);
        cmp({qd, id}, 32'h80000);
        cmp(n_cap - n, 32'h0);
    endtask
    task t_cal;
        logic [9:0] a, b, c;
        wb(1'b1, REG_CTRL, 32'h01);
        set_raw(10'h205, 10'h1FE);
        wb(1'b1, REG_CTRL, 32'h21);
        wb(1'b0, REG_STATUS, 32'h0);
        cmp(r & 32'h1, 32'h1);
        repeat (210) @(posedge clk);
        wb(1'b0, REG_OFFSET, 32'h0);
        cmp(r, 32'h03FE0005);
        wb(1'b0, REG_STATUS, 32'h0);
        cmp(r & 32'h1, 32'h0);
        grab(a, b, c);
        cmp({c, a}, 32'h80200);
        set_raw(10'h000, 10'h3FF);
        grab(a, b, c);
        cmp({c, a}, 32'hFFC00);
    endtask
    // Buffer through the top: one word per period, latency fixed after
    // each strobe, offsets I 5 and Q -2 still applied
    task t_fifo;
        int n, m;
        wb(1'b1, REG_CTRL, 32'h01);
        set_raw(10'h205, 10'h1FE);
        repeat (2) strobe_wait();
        m = n_cap;
        for (n = 0; n < 4; n++) begin
            si <= 10'h205 + 10'h040 * 10'(n);
            strobe_wait();
            repeat (2) @(posedge clk);
            cmp(id, 32'h200 + 32'h40 * 32'(n));
        end
        cmp(qd, 32'h200);
        cmp(n_cap - m, 32'h5);
        cmp(fr, 32'h1);
    endtask
    initial begin
        clk = 0;
        rst = 1;
        {cyc, stb, wen} = '0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'h1;
        si = 10'h200;
        sq = 10'h200;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_mux();
        t_par();
        t_power();
        t_cal();
        t_fifo();
        conclude();
    end
endmodule // test_dual_adc_output_control
